// ===== common/adc_ctrl_pkg.sv
// constants, field positions and state types for the converter control block
// assumes a single 200 MHz core clock; all timing counts derive from its period
package adc_ctrl_pkg;

  // result and pin layout
  localparam int RESULT_W = 12;
  localparam int BYTE_W = 8;
  localparam int LOW_NIB_W = 4;
  localparam int CHAN_W = 2;
  localparam int FIFO_DEPTH = 16;

  // synchroniser bit positions
  localparam int SYNC_W = 10;
  localparam int SY_CS_N = 0;
  localparam int SY_RC = 1;
  localparam int SY_BYTE = 2;
  localparam int SY_CONTINUOUS_CONVERT = 3;
  localparam int SY_POWER_DOWN = 4;
  localparam int SY_FMT = 5;
  localparam int SY_SRC = 6;
  localparam int SY_SCLK = 7;
  localparam int SY_CH_LO = 8;
  localparam int SY_CH_HI = 9;

  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CONV_TIME_NS = 8000;
  localparam int CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int SCLK_TICK_NS = 100;
  localparam int SCLK_TICK_CYCLES = (SCLK_TICK_NS * 1000) / CLK_PERIOD_PS;
  localparam int CONV_CNT_W = 16;
  localparam int TICK_CNT_W = 8;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] SERIAL_BITS = 4'hC;

  // reset values
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
  localparam logic [CHAN_W-1:0] CHAN_RST = 2'h0;
  localparam logic [LOW_NIB_W-1:0] LOW_PAD = 4'h0;
  // synchroniser idle: select and read/convert high, no request
  localparam logic [SYNC_W-1:0] SYNC_RST = 10'h003;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONVERT = 2'b01,
    ST_STORE = 2'b10,
    ST_WAIT_REG = 2'b11
  } state_t;

  typedef enum logic [1:0] {
    PH_RISE = 2'b00,
    PH_FALL = 2'b01,
    PH_HOLD = 2'b10,
    PH_SHIFT = 2'b11
  } sclk_phase_t;

endpackage

// ===== common/stream_if.sv
// valid/ready word carrier between the control block and its result buffer
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 12);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport producer (output valid, output data, input ready);
  modport consumer (input valid, input data, output ready);
endinterface // stream_if

// ===== hw/result_fifo.sv
// synchronous result buffer with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // fill and drain sides
  stream_if.consumer wr,
  stream_if.producer rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr;
  logic [AW-1:0] rd_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign wr.ready = (count != (AW+1)'(DEPTH));
  assign rd.valid = (count != '0);
  assign rd.data = mem[rd_ptr];
  assign push = wr.valid & wr.ready;
  assign pop = rd.valid & rd.ready;

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= wr.data;
    end
  end
endmodule // result_fifo

// ===== hw/adc_conversion_and_readout_control.sv
// conversion start, busy flag, parallel and serial readout of a 12-bit converter
// assumes pins asynchronous to core_clk; core_result valid at end of conversion time
`timescale 1ns/1ps
// Behaviour
// - byte low gives upper eight, high lower four
// - byte change while reading switches data pins
// - read/convert falling with select low starts conversion
// - read/convert rising enables parallel or external serial
// - select ORed with read/convert; select fall converts
// - select fall with read high enables readout
// - busy low from start until result latched
// - parallel data valid at busy rising edge
// - continuous mode cycles four channels, serial only
// - power down inhibits conversion, keeps result
// - power down in continuous resets channel zero
// - two's complement, serial MSB first, stable edges
// - convert requests while busy are ignored
// - internal clock sends previous result, busy covers
// - select tied low, read/convert alone controls
// - parallel outputs driven only reading, else off
// - low byte LSB lands on data pin four
// - clock source low internal, high external
module adc_conversion_and_readout_control
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_CYCLES_P = CONV_CYCLES,
  parameter int SCLK_TICK_CYCLES_P = SCLK_TICK_CYCLES,
  parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // host control pins
  input wire logic chip_select_n,
  input wire logic read_convert,
  input wire logic byte_select,
  input wire logic continuous_convert,
  input wire logic power_down,
  input wire logic output_format_select,
  input wire logic serial_clock_source,
  // channel address pins
  input wire logic channel_sel_lo_in,
  input wire logic channel_sel_hi_in,
  output logic channel_sel_lo_out,
  output logic channel_sel_hi_out,
  output logic channel_sel_lo_oe,
  output logic channel_sel_hi_oe,
  // parallel data pins
  output logic [BYTE_W-1:0] parallel_data_pins,
  output logic [BYTE_W-1:0] parallel_data_oe,
  // serial pins
  output logic serial_out,
  output logic serial_out_oe,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  // status
  output logic busy_n,
  // analog core
  input wire logic [RESULT_W-1:0] core_result,
  output logic sample_hold,
  output logic [CHAN_W-1:0] mux_channel
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [SYNC_W-1:0] pin_meta, pin_sync, next_pin_meta;
  logic cs_n_s, rc_s, byte_s, continuous_convert_s, power_down_s, fmt_s, src_s, sclk_s;
  logic [CHAN_W-1:0] chan_pin_s;

  always_comb begin
    next_pin_meta = '0;
    next_pin_meta[SY_CS_N] = chip_select_n;
    next_pin_meta[SY_RC] = read_convert;
    next_pin_meta[SY_BYTE] = byte_select;
    next_pin_meta[SY_CONTINUOUS_CONVERT] = continuous_convert;
    next_pin_meta[SY_POWER_DOWN] = power_down;
    next_pin_meta[SY_FMT] = output_format_select;
    next_pin_meta[SY_SRC] = serial_clock_source;
    next_pin_meta[SY_SCLK] = serial_clock_pin_in;
    next_pin_meta[SY_CH_LO] = channel_sel_lo_in;
    next_pin_meta[SY_CH_HI] = channel_sel_hi_in;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pin_meta <= SYNC_RST;
      pin_sync <= SYNC_RST;
    end else begin
      pin_meta <= next_pin_meta;
      pin_sync <= pin_meta;
    end
  end

  assign cs_n_s = pin_sync[SY_CS_N];
  assign rc_s = pin_sync[SY_RC];
  assign byte_s = pin_sync[SY_BYTE];
  assign continuous_convert_s = pin_sync[SY_CONTINUOUS_CONVERT];
  assign power_down_s = pin_sync[SY_POWER_DOWN];
  assign fmt_s = pin_sync[SY_FMT];
  assign src_s = pin_sync[SY_SRC];
  assign sclk_s = pin_sync[SY_SCLK];
  assign chan_pin_s = {pin_sync[SY_CH_HI], pin_sync[SY_CH_LO]};

  ////////////////////////////////////////////////////////////////////////
  // result buffer

  stream_if #(.WIDTH(RESULT_W)) wr_if ();
  stream_if #(.WIDTH(RESULT_W)) rd_if ();

  result_fifo #(.WIDTH(RESULT_W), .DEPTH(FIFO_DEPTH_P)) u_result_fifo (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .wr(wr_if.consumer),
    .rd(rd_if.producer)
  );

  ////////////////////////////////////////////////////////////////////////
  // control state

  state_t state, next_state;
  sclk_phase_t phase, next_phase;
  logic [CONV_CNT_W-1:0] conv_count, next_conv_count;
  logic [TICK_CNT_W-1:0] tick_count, next_tick_count;
  logic [BIT_CNT_W-1:0] tx_bits, next_tx_bits;
  logic [RESULT_W-1:0] out_reg, next_out_reg;
  logic [RESULT_W-1:0] result_hold, next_result_hold;
  logic [RESULT_W-1:0] tx_shift, next_tx_shift;
  logic [CHAN_W-1:0] chan_count, next_chan_count;
  logic [CHAN_W-1:0] next_mux_channel;
  logic tx_active, next_tx_active, tx_ext, next_tx_ext;
  logic sclk_int, next_sclk_int;
  logic read_en_prev, sclk_prev;
  logic next_busy_n, next_sample_hold;
  logic [BYTE_W-1:0] next_par_data, next_par_oe;
  logic next_serial_out_oe, next_sclk_oe, next_chan_oe;
  logic conv_req, read_en, start, pop, tick, int_tx;

  // combined select / read-convert, low means convert
  assign conv_req = !(cs_n_s | rc_s);
  assign read_en = !cs_n_s & rc_s;
  assign int_tx = tx_active & !tx_ext;
  assign tick = (tick_count == TICK_CNT_W'(SCLK_TICK_CYCLES_P - 1));
  assign wr_if.valid = (state == ST_STORE);
  assign wr_if.data = result_hold;
  // result register is held while an external shift is under way
  assign rd_if.ready = !(tx_active & tx_ext);
  assign pop = rd_if.valid & rd_if.ready;

  always_comb begin
    next_state = state;
    next_phase = phase;
    next_conv_count = conv_count;
    next_tick_count = tick ? '0 : tick_count + 1'b1;
    next_tx_bits = tx_bits;
    next_out_reg = out_reg;
    next_result_hold = result_hold;
    next_tx_shift = tx_shift;
    next_chan_count = chan_count;
    next_mux_channel = mux_channel;
    next_tx_active = tx_active;
    next_tx_ext = tx_ext;
    next_sclk_int = sclk_int;
    next_sample_hold = sample_hold;
    // level triggered start, refused while busy or powered down
    start = (state == ST_IDLE) && !int_tx && conv_req && !power_down_s;

    if (continuous_convert_s && power_down_s) begin
      next_chan_count = CHAN_RST;
    end

    unique case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_CONVERT;
          next_conv_count = '0;
          next_sample_hold = 1'b1;
          // continuous cycling only with serial output
          next_mux_channel = (continuous_convert_s && !fmt_s) ? chan_count : chan_pin_s;
          if (!fmt_s && !src_s) begin
            next_tx_active = 1'b1;
            next_tx_ext = 1'b0;
            next_tx_shift = out_reg;
            next_tx_bits = SERIAL_BITS;
            next_phase = PH_RISE;
            next_sclk_int = 1'b0;
            next_tick_count = '0;
          end
        end
      end
      ST_CONVERT: begin
        next_conv_count = conv_count + 1'b1;
        if (conv_count == CONV_CNT_W'(CONV_CYCLES_P - 1)) begin
          next_result_hold = core_result;
          next_sample_hold = 1'b0;
          next_state = ST_STORE;
          if (continuous_convert_s && !fmt_s && !power_down_s) begin
            next_chan_count = chan_count + 1'b1;
          end
        end
      end
      ST_STORE: begin
        if (wr_if.ready) begin
          next_state = ST_WAIT_REG;
        end
      end
      ST_WAIT_REG: begin
        if (pop) begin
          next_state = ST_IDLE;
        end
      end
    endcase

    // output register changes only when the buffered result is popped: after a conversion, or once an external shift ends
    if (pop) begin
      next_out_reg = rd_if.data;
    end

    // internal clock: data set up before rise, held past fall
    if (int_tx && tick) begin
      unique case (phase)
        PH_RISE: begin
          next_sclk_int = 1'b1;
          next_phase = PH_FALL;
        end
        PH_FALL: begin
          next_sclk_int = 1'b0;
          next_phase = PH_HOLD;
        end
        PH_HOLD: begin
          next_phase = PH_SHIFT;
        end
        PH_SHIFT: begin
          next_tx_shift = {tx_shift[RESULT_W-2:0], 1'b0};
          next_tx_bits = tx_bits - 1'b1;
          next_phase = PH_RISE;
          if (tx_bits == BIT_CNT_W'(1)) begin
            next_tx_active = 1'b0;
          end
        end
      endcase
    end

    // external clock transmission
    if (!tx_active && !fmt_s && src_s && read_en && !read_en_prev) begin
      next_tx_active = 1'b1;
      next_tx_ext = 1'b1;
      next_tx_shift = out_reg;
      next_tx_bits = SERIAL_BITS;
    end else if (tx_active && tx_ext) begin
      if (!read_en) begin
        next_tx_active = 1'b0;
      end else if (sclk_prev && !sclk_s) begin
        next_tx_shift = {tx_shift[RESULT_W-2:0], 1'b0};
        next_tx_bits = tx_bits - 1'b1;
        if (tx_bits == BIT_CNT_W'(1)) begin
          next_tx_active = 1'b0;
        end
      end
    end

    // busy covers conversion, latch and internal transmission
    next_busy_n = (next_state == ST_IDLE) && !(next_tx_active && !next_tx_ext);

    // parallel readout from the next result so data changes on the same edge as busy rising
    next_par_data = byte_s ? {next_out_reg[LOW_NIB_W-1:0], LOW_PAD}
                           : next_out_reg[RESULT_W-1:LOW_NIB_W];
    next_par_oe = {BYTE_W{fmt_s & read_en}};

    next_serial_out_oe = !fmt_s && (src_s ? read_en : !next_busy_n);
    next_sclk_oe = !fmt_s && !src_s;
    next_chan_oe = continuous_convert_s;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      phase <= PH_RISE;
      conv_count <= '0;
      tick_count <= '0;
      tx_bits <= '0;
      out_reg <= RESULT_RST;
      result_hold <= RESULT_RST;
      tx_shift <= RESULT_RST;
      chan_count <= CHAN_RST;
      mux_channel <= CHAN_RST;
      tx_active <= 1'b0;
      tx_ext <= 1'b0;
      sclk_int <= 1'b0;
      read_en_prev <= 1'b0;
      sclk_prev <= 1'b0;
      sample_hold <= 1'b0;
      busy_n <= 1'b1;
      parallel_data_pins <= '0;
      parallel_data_oe <= '0;
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe <= 1'b0;
      channel_sel_lo_out <= 1'b0;
      channel_sel_hi_out <= 1'b0;
      channel_sel_lo_oe <= 1'b0;
      channel_sel_hi_oe <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      conv_count <= next_conv_count;
      tick_count <= next_tick_count;
      tx_bits <= next_tx_bits;
      out_reg <= next_out_reg;
      result_hold <= next_result_hold;
      tx_shift <= next_tx_shift;
      chan_count <= next_chan_count;
      mux_channel <= next_mux_channel;
      tx_active <= next_tx_active;
      tx_ext <= next_tx_ext;
      sclk_int <= next_sclk_int;
      read_en_prev <= read_en;
      sclk_prev <= sclk_s;
      sample_hold <= next_sample_hold;
      busy_n <= next_busy_n;
      parallel_data_pins <= next_par_data;
      parallel_data_oe <= next_par_oe;
      serial_out <= next_tx_shift[RESULT_W-1];
      serial_out_oe <= next_serial_out_oe;
      serial_clock_pin_out <= next_sclk_int;
      serial_clock_pin_oe <= next_sclk_oe;
      channel_sel_lo_out <= next_chan_count[0];
      channel_sel_hi_out <= next_chan_count[1];
      channel_sel_lo_oe <= next_chan_oe;
      channel_sel_hi_oe <= next_chan_oe;
    end
  end

endmodule // adc_conversion_and_readout_control

// ===== verif/adc_ctrl_props.sv
// checker on the converter control block's top-level pins
// assumes pins reach the logic through two flops and outputs follow one edge later
`timescale 1ns/1ps
module adc_ctrl_props
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_CYCLES_P = CONV_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // host pins
  input wire logic chip_select_n,
  input wire logic read_convert,
  input wire logic byte_select,
  input wire logic continuous_convert,
  input wire logic power_down,
  input wire logic output_format_select,
  // block outputs
  input wire logic channel_sel_lo_out,
  input wire logic channel_sel_hi_out,
  input wire logic [BYTE_W-1:0] parallel_data_pins,
  input wire logic [BYTE_W-1:0] parallel_data_oe,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe,
  input wire logic busy_n,
  input wire logic sample_hold
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  // busy length and serial pulse counters
  logic [15:0] low_cnt, next_low_cnt;
  logic [3:0] pulse_cnt, next_pulse_cnt;
  logic sclk_d, next_sclk_d;
  always_comb begin
    next_low_cnt = busy_n ? 16'h0000 : low_cnt + 16'h0001;
    next_pulse_cnt = busy_n ? 4'h0 : pulse_cnt + {3'h0, serial_clock_pin_out & ~sclk_d};
    next_sclk_d = serial_clock_pin_out;
  end
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      low_cnt <= 16'h0000;
      pulse_cnt <= 4'h0;
      sclk_d <= 1'h0;
    end else begin
      low_cnt <= next_low_cnt;
      pulse_cnt <= next_pulse_cnt;
      sclk_d <= next_sclk_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    $fell(busy_n);
  endsequence
  sequence s_done;
    $rose(busy_n);
  endsequence
  a_busy_span: assert property (s_done |-> low_cnt >= CONV_CYCLES_P)
    else $error("busy low too short");
  a_start_hold: assert property (s_start |-> sample_hold)
    else $error("hold missing at start");
  a_hold_busy: assert property (sample_hold |-> !busy_n)
    else $error("hold without busy");
  a_start_cause: assert property (s_start |->
    $past(!chip_select_n && !read_convert && !power_down, 3))
    else $error("start without request");
  a_oe_read: assert property (parallel_data_oe[0] |->
    $past(!chip_select_n && read_convert && output_format_select, 3))
    else $error("data driven outside read");
  a_oe_whole: assert property (parallel_data_oe != 8'h00 |-> parallel_data_oe == 8'hFF)
    else $error("partial data enable");
  a_low_pad: assert property (parallel_data_oe[0] && $past(byte_select, 3)
    && $past(byte_select, 4) |-> parallel_data_pins[3:0] == 4'h0)
    else $error("low byte pad not zero");
  a_ch_zero: assert property ($past(continuous_convert && power_down, 3)
    && $past(continuous_convert && power_down, 4)
    |-> {channel_sel_hi_out, channel_sel_lo_out} == 2'h0)
    else $error("channel not reset");
  a_ser_pulses: assert property ((s_done and serial_clock_pin_oe) |-> pulse_cnt == 4'hC)
    else $error("serial pulse count wrong");
endmodule // adc_ctrl_props

bind adc_conversion_and_readout_control adc_ctrl_props #(
  .CONV_CYCLES_P(CONV_CYCLES_P)
) props (
  .core_clk, .reset_n, .chip_select_n, .read_convert, .byte_select,
  .continuous_convert, .power_down, .output_format_select,
  .channel_sel_lo_out, .channel_sel_hi_out, .parallel_data_pins, .parallel_data_oe,
  .serial_clock_pin_out, .serial_clock_pin_oe, .busy_n, .sample_hold
);

// ===== verif/adc_core_model.sv
// analog core stand-in returning a held conversion code
// assumes the bench sets the code before each conversion starts
`timescale 1ns/1ps
module adc_core_model
  import adc_ctrl_pkg::*;
(
  // clock
  input wire logic core_clk,
  // control block side
  input wire logic sample_hold,
  input wire logic [RESULT_W-1:0] code_in,
  output logic [RESULT_W-1:0] core_result
);
  logic [RESULT_W-1:0] held, next_held;
  always_comb begin
    next_held = sample_hold ? held : code_in;
  end
  always_ff @(posedge core_clk) begin
    held <= next_held;
  end
  // code only valid while held, inverted otherwise
  assign core_result = sample_hold ? held : ~held;
endmodule // adc_core_model

// ===== verif/tb_adc_conversion_and_readout_control.sv
// self-checking bench for the converter control block
// assumes core stand-in and checker compiled alongside
`timescale 1ns/1ps
module tb_adc_conversion_and_readout_control
  import adc_ctrl_pkg::*;
;
  logic core_clk;
  logic reset_n = 1'h0;
  logic chip_select_n = 1'h1;
  logic read_convert = 1'h1;
  logic byte_select = 1'h0;
  logic continuous_convert = 1'h0;
  logic power_down = 1'h0;
  logic output_format_select = 1'h1;
  logic serial_clock_source = 1'h0;
  logic channel_sel_lo_in = 1'h0;
  logic channel_sel_hi_in = 1'h0;
  logic serial_clock_pin_in = 1'h0;
  logic [11:0] code = 12'h000;
  logic [11:0] core_result, last = 12'h000, sh;
  logic [7:0] parallel_data_pins, parallel_data_oe;
  logic channel_sel_lo_out, channel_sel_hi_out, channel_sel_lo_oe, channel_sel_hi_oe;
  logic serial_out, serial_out_oe, serial_clock_pin_out, serial_clock_pin_oe;
  logic busy_n, sample_hold, busy_prev = 1'h1, sclk_now, sclk_prev = 1'h0;
  logic [1:0] mux_channel;
  logic [15:0] lfsr = 16'h0040;
  logic [11:0] exp_q[$], ser_q[$];
  int error_cnt = 0, n_compared = 0, nb = 0;

  adc_conversion_and_readout_control #(
    .CONV_CYCLES_P(60), .SCLK_TICK_CYCLES_P(2), .FIFO_DEPTH_P(FIFO_DEPTH)
  ) dut (
    .core_clk, .reset_n, .chip_select_n, .read_convert, .byte_select,
    .continuous_convert, .power_down, .output_format_select, .serial_clock_source,
    .channel_sel_lo_in, .channel_sel_hi_in, .channel_sel_lo_out, .channel_sel_hi_out,
    .channel_sel_lo_oe, .channel_sel_hi_oe, .parallel_data_pins, .parallel_data_oe,
    .serial_out, .serial_out_oe, .serial_clock_pin_in, .serial_clock_pin_out,
    .serial_clock_pin_oe, .busy_n, .core_result, .sample_hold, .mux_channel
  );
  adc_core_model core (.core_clk, .sample_hold, .code_in(code), .core_result);

  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp_val(input logic [11:0] got, input logic [11:0] want);
    n_compared++;
    if (got !== want) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic want);
    cmp_val({11'h000, got}, {11'h000, want});
  endtask
  task automatic wait_busy(input logic lvl);
    int i;
    for (i = 0; i < 3000 && busy_n !== lvl; i++) tick(1);
    if (i == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic convert(input logic by_cs, input logic extra);
    tick(5000);
    code = lfsr[11:0];
    lfsr = lfsr_step(lfsr);
    channel_sel_lo_in = lfsr[0];
    channel_sel_hi_in = lfsr[1];
    if (output_format_select) exp_q.push_back({4'h0, code[11:4]});
    else ser_q.push_back(last);
    chip_select_n = by_cs;
    read_convert = 1'h0;
    if (by_cs) begin
      tick(3);
      chip_select_n = 1'h0;
    end
    tick(10);
    read_convert = 1'h1;
    if (extra) begin
      tick(4);
      read_convert = 1'h0;
      tick(10);
      read_convert = 1'h1;
    end
    wait_busy(1'h1);
    last = code;
    tick(3);
    if (extra) cmp_flag(busy_n, 1'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // result watchers
  always @(posedge core_clk) begin
    #2;
    if (reset_n && busy_n && !busy_prev && parallel_data_oe[0] && exp_q.size() > 0)
      cmp_val({4'h0, parallel_data_pins}, exp_q.pop_front());
    busy_prev = busy_n;
  end
  always @(posedge core_clk) begin
    #2;
    sclk_now = serial_clock_source ? serial_clock_pin_in : serial_clock_pin_out;
    if (reset_n && serial_out_oe === 1'h1 && sclk_now && !sclk_prev) begin
      sh = {sh[10:0], serial_out};
      nb++;
    end
    if (nb == 12) begin
      nb = 0;
      if (ser_q.size() > 0) cmp_val(sh, ser_q.pop_front());
    end
    sclk_prev = sclk_now;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(4);
    reset_n = 1'h1;
    tick(2);
    convert(1'h1, 1'h0);
    convert(1'h0, 1'h1);
    byte_select = 1'h1;
    tick(5);
    cmp_val({4'h0, parallel_data_pins}, {4'h0, last[3:0], 4'h0});
    byte_select = 1'h0;
    tick(5);
    cmp_val({4'h0, parallel_data_pins}, {4'h0, last[11:4]});
    chip_select_n = 1'h1;
    tick(5);
    cmp_flag(parallel_data_oe[0], 1'h0);
    power_down = 1'h1;
    tick(3);
    chip_select_n = 1'h0;
    read_convert = 1'h0;
    tick(10);
    cmp_flag(busy_n, 1'h1);
    read_convert = 1'h1;
    tick(5);
    cmp_val({4'h0, parallel_data_pins}, {4'h0, last[11:4]});
    power_down = 1'h0;
    output_format_select = 1'h0;
    tick(5);
    cmp_flag(parallel_data_oe[0], 1'h0);
    cmp_flag(serial_clock_pin_oe, 1'h1);
    convert(1'h0, 1'h0);
    convert(1'h0, 1'h0);
    continuous_convert = 1'h1;
    power_down = 1'h1;
    read_convert = 1'h0;
    tick(8);
    cmp_val({10'h000, channel_sel_hi_out, channel_sel_lo_out}, 12'h000);
    cmp_flag(channel_sel_lo_oe & channel_sel_hi_oe, 1'h1);
    power_down = 1'h0;
    for (int k = 0; k < 4; k++) begin
      wait_busy(1'h0);
      cmp_val({10'h000, mux_channel}, k[11:0]);
      ser_q.push_back(last);
      wait_busy(1'h1);
    end
    // one more cycle starts before the released pins are seen
    chip_select_n = 1'h1;
    read_convert = 1'h1;
    continuous_convert = 1'h0;
    ser_q.push_back(last);
    tick(4);
    wait_busy(1'h1);
    tick(4);
    serial_clock_source = 1'h1;
    tick(4);
    ser_q.push_back(last);
    chip_select_n = 1'h0;
    tick(5);
    #2.3;
    repeat (12) begin
      #80 serial_clock_pin_in = 1'h1;
      #80 serial_clock_pin_in = 1'h0;
    end
    tick(6);
    cmp_flag(serial_out_oe, 1'h1);
    chip_select_n = 1'h1;
    cmp_flag(exp_q.size() == 0 && ser_q.size() == 0, 1'h1);
    tally_and_finish();
  end
endmodule // tb_adc_conversion_and_readout_control
